// ==== line_card_error_counters_pkg.sv ====
// constants for the line card error counter block
package line_card_error_counters_pkg;
  // clock and poll timeout
  localparam longint unsigned CLK_HZ = 64'd125_000_000;
  localparam longint unsigned POLL_TMO_S = 64'd7; // seconds without a poll
  localparam longint unsigned POLL_TMO_CYC = POLL_TMO_S * CLK_HZ;
  // bus widths
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned CNT_W = 32;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] LC_SEL_OFS = 8'h10;
  localparam logic [7:0] LC_WIN_OFS = 8'h20; // four words, selected card
  localparam logic [7:0] CX_WIN_OFS = 8'h80; // coax counters, one word each
  // control and status bits
  localparam int unsigned CTRL_ASCII_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned STAT_HOST_NR_BIT = 0;
  localparam int unsigned STAT_TERM_NR_BIT = 1;
  // interrupt bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_HOST_NR = 0;
  localparam int unsigned IRQ_TERM_NR = 1;
  localparam int unsigned IRQ_SAT = 2;
  // reset values
  localparam logic CTRL_ASCII_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [7:0] LC_SEL_RST = 8'h00;
  // per line card counter kinds
  localparam int unsigned LC_KINDS = 4;
  localparam int unsigned LC_PARITY = 0;
  localparam int unsigned LC_OVERRUN = 1;
  localparam int unsigned LC_FIFO = 2;
  localparam int unsigned LC_TXERR = 3;
  // host coax group
  localparam int unsigned H_FIFO = 0;
  localparam int unsigned H_PARITY = 1;
  localparam int unsigned H_ENDSEQ = 2;
  localparam int unsigned H_MIDBIT = 3;
  localparam int unsigned H_NORESP = 4;
  localparam int unsigned H_NOPOLLACK = 5;
  // terminal coax group, offsets within group
  localparam int unsigned T_FIFO = 0;
  localparam int unsigned T_PARITY = 1;
  localparam int unsigned T_ENDSEQ = 2;
  localparam int unsigned T_MIDBIT = 3;
  localparam int unsigned T_NORESP = 4;
  localparam int unsigned T_BADKEY = 5;
  localparam int unsigned T_DEVCHK = 6;
  localparam int unsigned T_RECONN = 7;
  localparam int unsigned T_BADASCII = 8;
  localparam int unsigned T_STATE1 = 9;
  localparam int unsigned T_STATE2 = 10;
  localparam int unsigned T_CNT = 11;
  localparam int unsigned NATIVE_BASE = 6;
  localparam int unsigned ASCII_BASE = 17;
  localparam int unsigned CX_CNT = 28;
endpackage

// ==== line_card_error_counters.sv ====
// saturating error counters for async and coax line cards, wishbone slave
`timescale 1ns/1ps
module line_card_error_counters #(
  parameter int unsigned LC_N = 4, // async line cards
  parameter int unsigned POLL_TMO =
    int'(line_card_error_counters_pkg::POLL_TMO_CYC)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [line_card_error_counters_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [line_card_error_counters_pkg::DAT_W-1:0] dat_i,
  output logic [line_card_error_counters_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // async line card event pulses, one bit per card
  input wire logic [LC_N-1:0] lc_parity_err_i,
  input wire logic [LC_N-1:0] lc_overrun_i,
  input wire logic [LC_N-1:0] lc_fifo_ovf_i,
  input wire logic [LC_N-1:0] lc_tx_err_i,
  // host-side coax event pulses
  input wire logic host_fifo_ovf_i,
  input wire logic host_parity_err_i,
  input wire logic host_endseq_err_i,
  input wire logic host_midbit_err_i,
  input wire logic host_poll_i,
  input wire logic host_poll_nak_i,
  // terminal-side coax event pulses
  input wire logic term_fifo_ovf_i,
  input wire logic term_parity_err_i,
  input wire logic term_endseq_err_i,
  input wire logic term_midbit_err_i,
  input wire logic term_no_resp_i,
  input wire logic term_resp_i,
  input wire logic term_bad_key_i,
  input wire logic term_dev_check_i,
  input wire logic term_reconnect_i,
  input wire logic term_bad_ascii_i,
  input wire logic term_state1_err_i,
  input wire logic term_state2_err_i,
  // status outputs
  output logic irq_o,
  output logic host_no_resp_o,
  output logic term_no_resp_o,
  output logic ascii_terminal_mode_o
);
  localparam int unsigned CNT_W = line_card_error_counters_pkg::CNT_W;
  localparam int unsigned CX_CNT = line_card_error_counters_pkg::CX_CNT;
  localparam int unsigned IRQ_W = line_card_error_counters_pkg::IRQ_W;
  localparam int unsigned LC_KINDS = line_card_error_counters_pkg::LC_KINDS;
  localparam int unsigned LC_CNT = LC_N * LC_KINDS;
  localparam int unsigned TMR_W = $clog2(POLL_TMO + 1);
  localparam logic [TMR_W-1:0] TMO = TMR_W'(POLL_TMO);
  localparam logic [CNT_W-1:0] CMAX = {CNT_W{1'b1}};

  // whole block state in one record
  typedef struct packed {
    logic [LC_CNT-1:0][CNT_W-1:0] lc_cnt; // async card counters
    logic [CX_CNT-1:0][CNT_W-1:0] cx_cnt; // coax counters
    logic [TMR_W-1:0] poll_tmr; // cycles since last host poll
    logic host_nr; // host stopped polling
    logic term_nr; // terminal stopped answering
    logic ascii; // ascii_terminal_mode
    logic [7:0] line_card_selector; // card seen in the window
    logic [IRQ_W-1:0] irq_stat; // sticky events
    logic [IRQ_W-1:0] irq_mask; // enables
    logic irq;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // saturating step; a clear in the same cycle as an event leaves one
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
      input logic ev, input logic clr);
    logic [CNT_W-1:0] r;
    r = clr ? '0 : v;
    if (ev && r != CMAX) begin
      r = r + 1'b1;
    end
    return r;
  endfunction

  logic req; // request not yet answered
  logic wr; // write taken this cycle
  logic [5:0] wadr; // word address
  logic [CX_CNT-1:0] cx_ev; // coax events this cycle
  logic [IRQ_W-1:0] irq_set; // hardware sets
  logic [IRQ_W-1:0] irq_clr; // software clears
  logic clear_all; // zero every counter
  logic host_nr_set; // host timeout reached now
  logic sat_hit; // a counter reached its ceiling

  // next state
  always_comb begin
    int unsigned base;
    int unsigned idx;
    logic clr;
    logic [CNT_W-1:0] nv;
    base = 0;
    idx = 0;
    clr = 1'b0;
    nv = '0;
    s_nxt = s_r;
    req = cyc_i && stb_i && !s_r.ack;
    wr = req && we_i;
    wadr = adr_i[7:2];
    sat_hit = 1'b0;
    irq_clr = '0;
    clear_all = 1'b0;
    // classic cycle: answer one cycle after the strobe, then drop
    s_nxt.ack = req;
    // register writes; all fields sit in byte lane 0
    if (wr && sel_i[0]) begin
      case (adr_i)
        line_card_error_counters_pkg::CTRL_OFS: begin
          s_nxt.ascii = dat_i[line_card_error_counters_pkg::CTRL_ASCII_BIT];
          clear_all = dat_i[line_card_error_counters_pkg::CTRL_CLEAR_BIT];
        end
        line_card_error_counters_pkg::IRQ_STAT_OFS: begin
          irq_clr = dat_i[IRQ_W-1:0];
        end
        line_card_error_counters_pkg::IRQ_MASK_OFS: begin
          s_nxt.irq_mask = dat_i[IRQ_W-1:0];
        end
        line_card_error_counters_pkg::LC_SEL_OFS: begin
          s_nxt.line_card_selector = dat_i[7:0];
        end
        default: begin
          // counters and unmapped words take no stored value
        end
      endcase
    end
    // host poll watchdog
    host_nr_set = !host_poll_i && s_r.poll_tmr == TMO - 1'b1;
    if (host_poll_i) begin
      s_nxt.poll_tmr = '0;
      s_nxt.host_nr = 1'b0;
    end else begin
      if (s_r.poll_tmr != TMO) begin
        s_nxt.poll_tmr = s_r.poll_tmr + 1'b1;
      end
      s_nxt.host_nr = s_r.host_nr || host_nr_set;
    end
    // terminal answer watch; a new miss beats an answer
    s_nxt.term_nr = term_no_resp_i || (s_r.term_nr && !term_resp_i);
    // coax events; host group counts in either mode
    cx_ev = '0;
    cx_ev[line_card_error_counters_pkg::H_FIFO] = host_fifo_ovf_i;
    cx_ev[line_card_error_counters_pkg::H_PARITY] = host_parity_err_i;
    cx_ev[line_card_error_counters_pkg::H_ENDSEQ] = host_endseq_err_i;
    cx_ev[line_card_error_counters_pkg::H_MIDBIT] = host_midbit_err_i;
    cx_ev[line_card_error_counters_pkg::H_NORESP] = host_nr_set;
    cx_ev[line_card_error_counters_pkg::H_NOPOLLACK] = host_poll_nak_i;
    // terminal group picked by mode
    base = s_r.ascii ? line_card_error_counters_pkg::ASCII_BASE
                     : line_card_error_counters_pkg::NATIVE_BASE;
    cx_ev[base + line_card_error_counters_pkg::T_FIFO] = term_fifo_ovf_i;
    cx_ev[base + line_card_error_counters_pkg::T_PARITY] = term_parity_err_i;
    cx_ev[base + line_card_error_counters_pkg::T_ENDSEQ] = term_endseq_err_i;
    cx_ev[base + line_card_error_counters_pkg::T_MIDBIT] = term_midbit_err_i;
    cx_ev[base + line_card_error_counters_pkg::T_NORESP] =
      term_no_resp_i && !s_r.term_nr;
    cx_ev[base + line_card_error_counters_pkg::T_BADKEY] = term_bad_key_i;
    // device check and ascii faults only exist in ascii mode
    cx_ev[base + line_card_error_counters_pkg::T_DEVCHK] =
      term_dev_check_i && s_r.ascii;
    cx_ev[base + line_card_error_counters_pkg::T_RECONN] =
      term_reconnect_i;
    cx_ev[base + line_card_error_counters_pkg::T_BADASCII] =
      term_bad_ascii_i && s_r.ascii;
    cx_ev[base + line_card_error_counters_pkg::T_STATE1] =
      term_state1_err_i;
    cx_ev[base + line_card_error_counters_pkg::T_STATE2] =
      term_state2_err_i;
    // async card counters; a write to a window word zeroes it
    for (int c = 0; c < LC_N; c++) begin
      for (int k = 0; k < LC_KINDS; k++) begin
        idx = c * LC_KINDS + k;
        clr = clear_all || (wr && s_r.line_card_selector == 8'(c) &&
          wadr == 6'((line_card_error_counters_pkg::LC_WIN_OFS >> 2) + k));
        nv = sat_inc(s_r.lc_cnt[idx],
          k == line_card_error_counters_pkg::LC_PARITY ? lc_parity_err_i[c] :
          k == line_card_error_counters_pkg::LC_OVERRUN ? lc_overrun_i[c] :
          k == line_card_error_counters_pkg::LC_FIFO ? lc_fifo_ovf_i[c] :
          lc_tx_err_i[c], clr);
        sat_hit = sat_hit || (nv == CMAX && s_r.lc_cnt[idx] != CMAX);
        s_nxt.lc_cnt[idx] = nv;
      end
    end
    // coax counters
    for (int i = 0; i < CX_CNT; i++) begin
      clr = clear_all || (wr &&
        wadr == 6'((line_card_error_counters_pkg::CX_WIN_OFS >> 2) + i));
      nv = sat_inc(s_r.cx_cnt[i], cx_ev[i], clr);
      sat_hit = sat_hit || (nv == CMAX && s_r.cx_cnt[i] != CMAX);
      s_nxt.cx_cnt[i] = nv;
    end
    // sticky events: a set in the clearing cycle survives
    irq_set = '0;
    irq_set[line_card_error_counters_pkg::IRQ_HOST_NR] = host_nr_set;
    irq_set[line_card_error_counters_pkg::IRQ_TERM_NR] =
      term_no_resp_i && !s_r.term_nr;
    irq_set[line_card_error_counters_pkg::IRQ_SAT] = sat_hit;
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    // read data; unmapped words read zero
    if (req && !we_i) begin
      s_nxt.dat = '0;
      if (adr_i == line_card_error_counters_pkg::CTRL_OFS) begin
        s_nxt.dat[line_card_error_counters_pkg::CTRL_ASCII_BIT] = s_r.ascii;
      end else if (adr_i == line_card_error_counters_pkg::STATUS_OFS) begin
        s_nxt.dat[line_card_error_counters_pkg::STAT_HOST_NR_BIT] = s_r.host_nr;
        s_nxt.dat[line_card_error_counters_pkg::STAT_TERM_NR_BIT] = s_r.term_nr;
      end else if (adr_i == line_card_error_counters_pkg::IRQ_STAT_OFS) begin
        s_nxt.dat[IRQ_W-1:0] = s_r.irq_stat;
      end else if (adr_i == line_card_error_counters_pkg::IRQ_MASK_OFS) begin
        s_nxt.dat[IRQ_W-1:0] = s_r.irq_mask;
      end else if (adr_i == line_card_error_counters_pkg::LC_SEL_OFS) begin
        s_nxt.dat[7:0] = s_r.line_card_selector;
      end else begin
        // counter windows; a card beyond LC_N reads zero
        for (int c = 0; c < LC_N; c++) begin
          for (int k = 0; k < LC_KINDS; k++) begin
            if (s_r.line_card_selector == 8'(c) && wadr ==
                6'((line_card_error_counters_pkg::LC_WIN_OFS >> 2) + k)) begin
              s_nxt.dat = s_r.lc_cnt[c * LC_KINDS + k];
            end
          end
        end
        for (int i = 0; i < CX_CNT; i++) begin
          if (wadr == 6'((line_card_error_counters_pkg::CX_WIN_OFS >> 2) + i))
              begin
            s_nxt.dat = s_r.cx_cnt[i];
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ascii <= line_card_error_counters_pkg::CTRL_ASCII_RST;
      s_r.irq_mask <= line_card_error_counters_pkg::IRQ_MASK_RST;
      s_r.line_card_selector <= line_card_error_counters_pkg::LC_SEL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign dat_o = s_r.dat;
  assign ack_o = s_r.ack;
  assign irq_o = s_r.irq;
  assign host_no_resp_o = s_r.host_nr;
  assign term_no_resp_o = s_r.term_nr;
  assign ascii_terminal_mode_o = s_r.ascii;

  // checks on card 0, the coax groups and the bus answer; the counter checks assume no bus write in flight
  AST_LC_PARITY: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_parity_err_i[0] && !(cyc_i && stb_i && we_i) && s_r.lc_cnt[0] < CMAX
    |=> s_r.lc_cnt[0] == $past(s_r.lc_cnt[0]) + 1'b1)
    else $error("parity count did not step");
  AST_LC_OVERRUN: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_overrun_i[0] && !(cyc_i && stb_i && we_i) && s_r.lc_cnt[1] < CMAX
    |=> s_r.lc_cnt[1] == $past(s_r.lc_cnt[1]) + 1'b1)
    else $error("overrun count did not step");
  AST_LC_FIFO: assert property (@(posedge clk_i) disable iff (rst_i)
    !lc_fifo_ovf_i[0] && !(cyc_i && stb_i && we_i) |=> $stable(s_r.lc_cnt[2]))
    else $error("fifo count moved without event");
  AST_LC_TX: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_tx_err_i[0] && !(cyc_i && stb_i && we_i) && s_r.lc_cnt[3] < CMAX
    |=> s_r.lc_cnt[3] > $past(s_r.lc_cnt[3]))
    else $error("tx error count did not step");
  AST_HOST_FIFO: assert property (@(posedge clk_i) disable iff (rst_i)
    host_fifo_ovf_i && !(cyc_i && stb_i && we_i) && s_r.cx_cnt[0] < CMAX
    |=> s_r.cx_cnt[0] == $past(s_r.cx_cnt[0]) + 1'b1)
    else $error("host fifo count did not step");
  AST_HOST_PARITY: assert property (@(posedge clk_i) disable iff (rst_i)
    host_parity_err_i && !(cyc_i && stb_i && we_i) && s_r.cx_cnt[1] < CMAX
    |=> s_r.cx_cnt[1] == $past(s_r.cx_cnt[1]) + 1'b1)
    else $error("host parity count did not step");
  AST_HOST_LINE: assert property (@(posedge clk_i) disable iff (rst_i)
    !host_endseq_err_i && !host_midbit_err_i && !(cyc_i && stb_i && we_i)
    |=> $stable(s_r.cx_cnt[2]) && $stable(s_r.cx_cnt[3]))
    else $error("host line fault count moved without event");
  AST_HOST_NR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.host_nr |-> s_r.poll_tmr == TMO)
    else $error("host no-response flag before the timeout");
  AST_POLL_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    host_poll_i |=> !host_no_resp_o ##1 s_r.poll_tmr <= 1)
    else $error("poll did not restart the watchdog");
  AST_TERM_NR: assert property (@(posedge clk_i) disable iff (rst_i)
    term_no_resp_i |=> term_no_resp_o)
    else $error("terminal no-response not flagged");
  AST_NOPOLLACK: assert property (@(posedge clk_i) disable iff (rst_i)
    host_poll_nak_i && !(cyc_i && stb_i && we_i) && s_r.cx_cnt[5] < CMAX
    |=> s_r.cx_cnt[5] == $past(s_r.cx_cnt[5]) + 1'b1)
    else $error("poll ack miss not counted");
  AST_DEVCHK_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.ascii && !(cyc_i && stb_i && we_i) |=> $stable(s_r.cx_cnt[12]))
    else $error("native device check counter moved");
  // ascii group reconnect counter sits at ascii base plus reconnect offset
  AST_TERM_RECONN: assert property (@(posedge clk_i) disable iff (rst_i)
    term_reconnect_i && s_r.ascii && !(cyc_i && stb_i && we_i) &&
    s_r.cx_cnt[24] < CMAX |=> s_r.cx_cnt[24] == $past(s_r.cx_cnt[24]) + 1'b1)
    else $error("reconnect count did not step");
  AST_MODE_SPLIT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.ascii && !(cyc_i && stb_i && we_i) |=> $stable(s_r.cx_cnt[6]))
    else $error("native group counted in ascii mode");
  AST_SATURATE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.lc_cnt[0] == CMAX && !(cyc_i && stb_i && we_i)
    |=> s_r.lc_cnt[0] == CMAX)
    else $error("counter wrapped");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle");
endmodule

// ==== host_poll_model.sv ====
// partner model: control unit polling the host coax
`timescale 1ns/1ps
module host_poll_model #(
  parameter int unsigned PERIOD = 10 // cycles between polls
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench control
  input wire logic poll_en_i,
  // coax side
  output logic poll_o
);
  // cycles since the last poll
  int unsigned cnt_r;
  // one-cycle poll every PERIOD cycles while enabled
  // disabling it is how the bench makes the control unit go silent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      poll_o <= 1'b0;
    end else if (poll_en_i && cnt_r == PERIOD - 1) begin
      cnt_r <= 0;
      poll_o <= 1'b1;
    end else begin
      cnt_r <= poll_en_i ? cnt_r + 1 : 0;
      poll_o <= 1'b0;
    end
  end
endmodule

// ==== line_card_error_counters_tb.sv ====
// self-checking bench for the line card error counters
`timescale 1ns/1ps
module line_card_error_counters_tb;
  localparam int unsigned LINE_CARD_SELECTOR = 4; // cards in this bench
  localparam int unsigned TMO = 20; // shortened poll timeout
  // clock, reset and bus
  logic clk, rst, cyc, stb, we, ack, irq, hnr, tnr, amode, poll, poll_en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  // event pulses: cards 15:0, host 20:16, terminal 32:21
  logic [32:0] ev;
  int bad_count, total_checks;

  host_poll_model #(.PERIOD(10)) cu_u (.clk_i(clk), .rst_i(rst),
    .poll_en_i(poll_en), .poll_o(poll));

  line_card_error_counters #(.LC_N(LINE_CARD_SELECTOR), .POLL_TMO(TMO)) dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .lc_parity_err_i(ev[3:0]), .lc_overrun_i(ev[7:4]),
    .lc_fifo_ovf_i(ev[11:8]), .lc_tx_err_i(ev[15:12]),
    .host_fifo_ovf_i(ev[16]), .host_parity_err_i(ev[17]),
    .host_endseq_err_i(ev[18]), .host_midbit_err_i(ev[19]),
    .host_poll_i(poll), .host_poll_nak_i(ev[20]),
    .term_fifo_ovf_i(ev[21]), .term_parity_err_i(ev[22]),
    .term_endseq_err_i(ev[23]), .term_midbit_err_i(ev[24]),
    .term_no_resp_i(ev[25]), .term_resp_i(ev[26]),
    .term_bad_key_i(ev[27]), .term_dev_check_i(ev[28]),
    .term_reconnect_i(ev[29]), .term_bad_ascii_i(ev[30]),
    .term_state1_err_i(ev[31]), .term_state2_err_i(ev[32]),
    .irq_o(irq), .host_no_resp_o(hnr), .term_no_resp_o(tnr),
    .ascii_terminal_mode_o(amode));

  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1, "bus ack missing");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp, what);
  endtask

  // coax counter i
  task rd_cx(input int i, input logic [31:0] exp);
    rd(line_card_error_counters_pkg::CX_WIN_OFS + 8'(4 * i), exp, "coax");
  endtask

  // n one-cycle pulses on event line i
  task fire(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
    end
  endtask

  // terminal counter j expected after one round, in either mode
  function automatic logic [31:0] texp(input int j, input logic asc);
    if (j == 4) return 32'h1;
    if (!asc && (j == 6 || j == 8)) return 32'h0;
    return 32'(j + 1);
  endfunction

  // one round of terminal events; no response is a rise then a clear
  task term_round;
    for (int j = 0; j < 11; j++) begin
      if (j == 4) begin
        fire(25, 1);
        @(posedge clk);
        check({31'h0, tnr}, 32'h1, "term no response up");
        fire(26, 1);
        @(posedge clk);
        check({31'h0, tnr}, 32'h0, "term no response down");
      end else begin
        fire(j < 4 ? 21 + j : 22 + j, j + 1);
      end
    end
  endtask

  // read both terminal groups against the expected table
  task term_read(input logic asc);
    for (int j = 0; j < 11; j++) begin
      rd_cx(line_card_error_counters_pkg::NATIVE_BASE + j, texp(j, 1'b0));
      rd_cx(line_card_error_counters_pkg::ASCII_BASE + j,
            asc ? texp(j, 1'b1) : 32'h0);
    end
  endtask

  task end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, well above the few hundred cycles the tests need
  initial begin
    #400000;
    check(32'h0, 32'h1, "watchdog expired");
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ev = '0;
    poll_en = 1'b1;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped word
    rd(line_card_error_counters_pkg::CTRL_OFS, 32'h0, "ctrl");
    rd(line_card_error_counters_pkg::STATUS_OFS, 32'h0, "status");
    rd(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h0, "irq stat");
    rd(line_card_error_counters_pkg::IRQ_MASK_OFS, 32'h0, "irq mask");
    rd(line_card_error_counters_pkg::LC_SEL_OFS, 32'h0, "card select");
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0, "unmapped");
    end_test("reset");
    // card 2 gets k+1 events of kind k, card 0 one of each, card 1 parity
    for (int k = 0; k < 4; k++) begin
      fire(k * 4 + 2, k + 1);
      fire(k * 4, 1);
    end
    fire(1, 1);
    wr(line_card_error_counters_pkg::LC_SEL_OFS, 32'h2);
    for (int k = 0; k < 4; k++)
      rd(line_card_error_counters_pkg::LC_WIN_OFS + 8'(4 * k),
         32'(k + 1), "card 2");
    wr(line_card_error_counters_pkg::LC_SEL_OFS, 32'h1);
    rd(line_card_error_counters_pkg::LC_WIN_OFS, 32'h1, "card 1");
    rd(line_card_error_counters_pkg::LC_WIN_OFS + 8'h4, 32'h0, "card 1");
    wr(line_card_error_counters_pkg::LC_SEL_OFS, 32'h0);
    for (int k = 0; k < 4; k++)
      rd(line_card_error_counters_pkg::LC_WIN_OFS + 8'(4 * k), 32'h1,
         "card 0");
    wr(line_card_error_counters_pkg::LC_SEL_OFS, 32'(LINE_CARD_SELECTOR));
    rd(line_card_error_counters_pkg::LC_WIN_OFS, 32'h0, "no card");
    end_test("line cards");
    // host coax faults; polls keep coming so no response stays 0
    for (int i = 0; i < 4; i++) fire(16 + i, i + 1);
    fire(20, 2);
    for (int i = 0; i < 4; i++) rd_cx(i, 32'(i + 1));
    rd_cx(line_card_error_counters_pkg::H_NOPOLLACK, 32'h2);
    rd_cx(line_card_error_counters_pkg::H_NORESP, 32'h0);
    wr(line_card_error_counters_pkg::CX_WIN_OFS + 8'h4, 32'h0);
    rd_cx(1, 32'h0);
    rd_cx(2, 32'h3);
    end_test("host coax");
    // clear all, then one round per terminal mode
    wr(line_card_error_counters_pkg::CTRL_OFS, 32'h2);
    rd_cx(0, 32'h0);
    rd(line_card_error_counters_pkg::CTRL_OFS, 32'h0, "clear reads 0");
    term_round();
    term_read(1'b0);
    wr(line_card_error_counters_pkg::CTRL_OFS, 32'h1);
    check({31'h0, amode}, 32'h1, "ascii mode pin");
    term_round();
    fire(16, 1);
    term_read(1'b1);
    rd_cx(0, 32'h1);
    end_test("terminal modes");
    // poll timeout, status, interrupt mask and clear
    // both terminal rounds raised the terminal no-response event
    rd(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h2, "term irq");
    wr(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h7);
    rd(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h0, "w1c");
    // stop polling right at a poll so the silent span is known
    for (int n = 0; n < 30 && poll !== 1'b1; n++) @(posedge clk);
    poll_en <= 1'b0;
    repeat (TMO - 3) @(posedge clk);
    check({31'h0, hnr}, 32'h0, "no response too early");
    for (int n = 0; n < 10 && hnr !== 1'b1; n++) @(posedge clk);
    check({31'h0, hnr}, 32'h1, "no response flag");
    check({31'h0, irq}, 32'h0, "masked irq");
    rd(line_card_error_counters_pkg::STATUS_OFS, 32'h1, "status");
    rd(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h1, "irq stat");
    rd_cx(line_card_error_counters_pkg::H_NORESP, 32'h1);
    wr(line_card_error_counters_pkg::IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1, "unmasked irq");
    poll_en <= 1'b1;
    for (int n = 0; n < 30 && hnr !== 1'b0; n++) @(posedge clk);
    check({31'h0, hnr}, 32'h0, "poll clears flag");
    wr(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rd(line_card_error_counters_pkg::IRQ_STAT_OFS, 32'h0, "irq stat");
    end_test("poll timeout");
    tally_and_finish();
  end
endmodule
